/* File: inc/fers_defs.vh */
`ifndef FERS_DEFS_VH
`define FERS_DEFS_VH
// =============================================================
// register byte offsets
`define FERS_OFF_RESULT   12'h000
`define FERS_OFF_CTRL     12'h004
`define FERS_OFF_IRQ_STAT 12'h008
`define FERS_OFF_IRQ_MASK 12'h00C
`define FERS_OFF_ARRAY    12'h010
`define FERS_OFF_KEY      12'h014
// =============================================================
// result register field positions
`define FERS_BIT_SETTING  6
`define FERS_BIT_ETIME    5
`define FERS_BIT_KEY      4
// =============================================================
// values and reset values
`define FERS_ARRAY_BOOT   8'hAA
`define FERS_KEY_GOOD     8'hA5
`define FERS_RESULT_RST   8'h00
`define FERS_MASK_RST     3'h0
// =============================================================
// timing: erase pulse length in ns at 25 ns period
`define FERS_ERASE_NS     1000
`define FERS_CLK_NS       25
`define FERS_ERASE_CYC    ((`FERS_ERASE_NS + `FERS_CLK_NS - 1) / `FERS_CLK_NS)
`endif

/* File: verilog/fers_erase_status.v */
// What this block does
// - check protection before erase, report bit 6
// - protection set: bit reads 1, no erase
// - protection clear: setting bit reads 0
// - user array erase failure sets bit 5
// - register tampering during user branch sets bit 5
// - array select AA at start flags bit 5, unless protected or key wrong
// - boot selected: erase neither array
// - successful erase leaves bit 5 at 0
// - bit 5 set means erase result unguaranteed
// - check key register, report bit 4
`timescale 1ns/1ps
`default_nettype none
`include "fers_defs.vh"

module fers_erase_status #(
    parameter ERASE_CYC = `FERS_ERASE_CYC
) (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        protect_error_state,
    input  wire        erase_fail,
    input  wire        branch_reg_changed,
    output reg         erase_busy,
    output reg         erase_strobe_user,
    output reg         irq
);

// =============================================================
// synchronisers for the status inputs from the flash macro
reg [1:0] prot_s_q;                 // protection state sync
reg [1:0] fail_s_q;                 // erase failure sync
reg [1:0] chg_s_q;                  // tamper detect sync

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        prot_s_q <= 2'h0;
        fail_s_q <= 2'h0;
        chg_s_q  <= 2'h0;
    end else begin
        prot_s_q <= {prot_s_q[0], protect_error_state};
        fail_s_q <= {fail_s_q[0], erase_fail};
        chg_s_q  <= {chg_s_q[0], branch_reg_changed};
    end
end

wire prot_w = prot_s_q[1];          // synchronised protection
wire fail_w = fail_s_q[1];          // synchronised failure
wire chg_w  = chg_s_q[1];           // synchronised tamper flag

// =============================================================
// registers
reg  [7:0]  result_q;               // erase result status
reg  [7:0]  array_sel_q;            // array select register
reg  [7:0]  key_q;                  // programming key register
reg  [2:0]  irq_stat_q;             // sticky events
reg  [2:0]  irq_mask_q;             // event enables
reg  [1:0]  state_q;                // sequencer state
reg  [15:0] cnt_q;                  // erase pulse counter
reg         tamper_q;               // tamper seen during erase

localparam ST_IDLE  = 2'h0;         // waiting for request
localparam ST_ERASE = 2'h1;         // erase pulse running
localparam ST_DONE  = 2'h2;         // record outcome

// =============================================================
// bus decode
wire acc    = psel & penable & ~pready;   // access phase, first cycle
wire fin    = psel & penable & pready;    // edge that ends the access
wire wr     = fin & pwrite;               // write lands as ready is seen
wire rd     = acc & ~pwrite;              // read data ready one cycle early
wire hit_rs = paddr == `FERS_OFF_RESULT;
wire hit_ct = paddr == `FERS_OFF_CTRL;
wire hit_is = paddr == `FERS_OFF_IRQ_STAT;
wire hit_im = paddr == `FERS_OFF_IRQ_MASK;
wire hit_as = paddr == `FERS_OFF_ARRAY;
wire hit_ky = paddr == `FERS_OFF_KEY;
wire hit    = hit_rs | hit_ct | hit_is | hit_im | hit_as | hit_ky;
wire start  = wr & hit_ct & pwdata[0] & (state_q == ST_IDLE);

// event pulses for the interrupt status
reg  [2:0]  ev_d;                   // setting, erase time, key

// =============================================================
// erase sequencer and result register
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        state_q           <= ST_IDLE;
        cnt_q             <= 16'h0000;
        tamper_q          <= 1'b0;
        result_q          <= `FERS_RESULT_RST;
        erase_busy        <= 1'b0;
        erase_strobe_user <= 1'b0;
        ev_d              <= 3'h0;
    end else begin
        ev_d <= 3'h0;
        case (state_q)
        ST_IDLE: begin
            if (start) begin
                // fresh result for each request; held otherwise
                result_q <= `FERS_RESULT_RST;
                result_q[`FERS_BIT_SETTING] <= prot_w;
                result_q[`FERS_BIT_KEY] <=
                    (key_q != `FERS_KEY_GOOD);
                if (prot_w || key_q != `FERS_KEY_GOOD) begin
                    // no erase when protected or key wrong
                    ev_d <= {prot_w, 1'b0,
                             key_q != `FERS_KEY_GOOD};
                end else if (array_sel_q == `FERS_ARRAY_BOOT) begin
                    // boot array selected: error, nothing erased
                    result_q[`FERS_BIT_ETIME] <= 1'b1;
                    ev_d <= 3'h2;
                end else begin
                    state_q           <= ST_ERASE;
                    cnt_q             <= 16'h0000;
                    tamper_q          <= 1'b0;
                    erase_busy        <= 1'b1;
                    erase_strobe_user <= 1'b1;
                end
            end
        end
        ST_ERASE: begin
            // watch for tampering while erase runs
            if (chg_w)
                tamper_q <= 1'b1;
            if (cnt_q == ERASE_CYC[15:0] - 16'h0001) begin
                erase_strobe_user <= 1'b0;
                state_q           <= ST_DONE;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
        ST_DONE: begin
            // error bit means result unguaranteed; clear on success
            result_q[`FERS_BIT_ETIME] <=
                fail_w | tamper_q | chg_w;
            ev_d       <= {1'b0, fail_w | tamper_q | chg_w, 1'b0};
            erase_busy <= 1'b0;
            state_q    <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
        endcase
    end
end

// =============================================================
// software registers, interrupt status and mask
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        array_sel_q <= 8'h00;
        key_q       <= 8'h00;
        irq_mask_q  <= `FERS_MASK_RST;
        irq_stat_q  <= 3'h0;
    end else begin
        if (wr && hit_as)
            array_sel_q <= pwdata[7:0];
        if (wr && hit_ky)
            key_q <= pwdata[7:0];
        if (wr && hit_im)
            irq_mask_q <= pwdata[2:0];
        // read clears; a new event in the same cycle wins
        if (rd && hit_is)
            irq_stat_q <= ev_d;
        else
            irq_stat_q <= irq_stat_q | ev_d;
    end
end

// =============================================================
// apb answer: one wait state per access
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
        irq     <= 1'b0;
    end else begin
        pready  <= acc;
        pslverr <= acc & ~hit;
        irq     <= |(irq_stat_q & irq_mask_q);
        if (rd) begin
            case (1'b1)
            hit_rs:  prdata <= {24'h000000, result_q};
            hit_ct:  prdata <= {31'h00000000, erase_busy};
            hit_is:  prdata <= {29'h00000000, irq_stat_q};
            hit_im:  prdata <= {29'h00000000, irq_mask_q};
            hit_as:  prdata <= {24'h000000, array_sel_q};
            hit_ky:  prdata <= {24'h000000, key_q};
            default: prdata <= 32'h00000000;
            endcase
        end
    end
end

endmodule // fers_erase_status
`default_nettype wire

/* File: test/fers_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checks of the erase result block
module fers_chk #(parameter ERASE_CYC = 40) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        protect_error_state,
    input wire logic        erase_busy,
    input wire logic        erase_strobe_user
);
    logic [7:0] cnt_q; // cycles of erase pulse
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // count pulse length
    always @(posedge sys_clk or posedge rst) begin
        if (rst) cnt_q <= 8'h00;
        else cnt_q <= erase_strobe_user ? cnt_q + 8'h01 : 8'h00;
    end
    AST_PROT_NO_ERASE: assert property (protect_error_state [*4] |=>
        !$rose(erase_strobe_user)) else $error("erase under protection");
    AST_STRB_IN_BUSY: assert property (erase_strobe_user |-> erase_busy)
        else $error("pulse outside busy");
    AST_BUSY_STRB: assert property ($rose(erase_busy) |->
        ##[0:1] erase_strobe_user or ##[0:1] !erase_busy)
        else $error("busy without pulse");
    AST_STRB_LEN: assert property ($fell(erase_strobe_user) |->
        cnt_q == ERASE_CYC) else $error("pulse length wrong");
    AST_BUSY_END: assert property ($fell(erase_strobe_user) |->
        ##[0:2] !erase_busy) else $error("busy stuck");
    AST_RDY_WAIT: assert property (psel && penable && !pready |=>
        pready) else $error("no ready");
    AST_RDY_PULSE: assert property (pready |=> !pready)
        else $error("ready too long");
    AST_ERR_PAIR: assert property (pslverr |-> pready)
        else $error("slverr without ready");
    AST_RES_BITS: assert property (pready && !pwrite && paddr == 12'h000
        |-> prdata[31:7] == 25'h0 && prdata[3:0] == 4'h0)
        else $error("result spare bits set");
endmodule // fers_chk
`default_nettype wire

/* File: test/test_fers_erase_status.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench of the erase result block
module test_fers_erase_status;
    localparam CYC = 4;               // shortened erase pulse
    logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, erase_busy, irq;
    logic        protect_error_state = 1'b0, erase_fail = 1'b0;
    logic        branch_reg_changed = 1'b0, erase_strobe_user, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0]  msk;                 // interrupt mask mirror
    int          fail_count = 0, n_checks = 0, strb_n = 0;
    fers_erase_status #(.ERASE_CYC(CYC)) u_fers_erase_status (.sys_clk,
        .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .protect_error_state, .erase_fail, .branch_reg_changed,
        .erase_busy, .erase_strobe_user, .irq);
    initial forever #12.5 sys_clk = ~sys_clk;
    // count erase pulse cycles
    always @(posedge sys_clk) strb_n <= strb_n + erase_strobe_user;
    task automatic check(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one apb transfer, bounded wait on ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(negedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            report_and_stop;
        end
        rd = prdata;
        err = pslverr;
        @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // reset value, read-only result, unmapped place
    task automatic s_regs;
        apb(1'b1, 12'h000, 32'hFF);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
    endtask
    // one erase request and its result, pulse count and interrupt
    task automatic s_erase(input logic p, f, t, input logic [7:0] k, a, e);
        int s;
        int n = 0;
        protect_error_state <= p;
        erase_fail <= f;
        branch_reg_changed <= t;
        apb(1'b1, 12'h014, {24'h0, k});
        apb(1'b1, 12'h010, {24'h0, a});
        s = strb_n;
        apb(1'b1, 12'h004, 32'h1);
        while (erase_busy !== 1'b0 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        check(n < 100, 1'b1);
        check(strb_n - s, (!p && k == 8'hA5 && a != 8'hAA) ? CYC : 0);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, {24'h0, e});
        check(irq, |(e[6:4] & msk));
        apb(1'b0, 12'h008, 32'h0);
        check(rd, {29'h0, e[6:4]});
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        s_regs;
        msk = 3'h7;
        apb(1'b1, 12'h00C, 32'h7);
        s_erase(0, 0, 0, 8'hA5, 8'h00, 8'h00);
        s_erase(1, 0, 0, 8'hA5, 8'h00, 8'h40);
        s_erase(0, 0, 0, 8'hA5, 8'h00, 8'h00);
        s_erase(0, 0, 0, 8'h3C, 8'h00, 8'h10);
        s_erase(0, 0, 0, 8'hA5, 8'hAA, 8'h20);
        s_erase(0, 1, 0, 8'hA5, 8'h00, 8'h20);
        s_erase(0, 0, 1, 8'hA5, 8'h00, 8'h20);
        msk = 3'h0;
        apb(1'b1, 12'h00C, 32'h0);
        s_erase(0, 1, 0, 8'hA5, 8'h00, 8'h20);
        report_and_stop;
    end
endmodule // test_fers_erase_status
bind fers_erase_status fers_chk #(.ERASE_CYC(ERASE_CYC)) u_fers_chk (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .protect_error_state, .erase_busy, .erase_strobe_user);
`default_nettype wire
